// ==== verilog/tc8_pkg.sv ====
/*
 * Package for the 8-bit timer compare block: register offsets, field
 * positions, mode codes and the packed state record.
 * Assumes an APB slave with 32-bit data, one aligned word per register.
 */
package tc8_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] TC8_OFF_CTRL = 8'h00;
	localparam logic [7:0] TC8_OFF_COUNT = 8'h04;
	localparam logic [7:0] TC8_OFF_CMPA = 8'h08;
	localparam logic [7:0] TC8_OFF_CMPB = 8'h0C;
	localparam logic [7:0] TC8_OFF_FLAGS = 8'h10;
	localparam logic [7:0] TC8_OFF_IEN = 8'h14;
	localparam logic [7:0] TC8_OFF_FORCE = 8'h18;
	localparam logic [7:0] TC8_OFF_PORT = 8'h1C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int TC8_CTRL_WSEL_LSB = 0;
	localparam int TC8_CTRL_ACTA_LSB = 4;
	localparam int TC8_CTRL_ACTB_LSB = 6;
	localparam int TC8_CTRL_TSEL_LSB = 8;
	localparam int TC8_FLAG_OVF = 0;
	localparam int TC8_FLAG_A = 1;
	localparam int TC8_FLAG_B = 2;
	localparam int TC8_PORT_DATA_LSB = 0;
	localparam int TC8_PORT_DIR_LSB = 4;

	// ----------------------------------------------------------------
	// Mode and action codes, counter limits
	// ----------------------------------------------------------------
	localparam logic [2:0] TC8_WSEL_NORMAL = 3'h0;
	localparam logic [2:0] TC8_WSEL_CLEAR_ON_MATCH = 3'h2;
	localparam logic [1:0] TC8_ACT_NONE = 2'h0;
	localparam logic [1:0] TC8_ACT_TOGGLE = 2'h1;
	localparam logic [1:0] TC8_ACT_CLEAR = 2'h2;
	localparam logic [1:0] TC8_ACT_SET = 2'h3;
	localparam logic [7:0] TC8_COUNT_MAX = 8'hFF;
	localparam logic [7:0] TC8_COUNT_BOTTOM = 8'h00;
	localparam logic [2:0] TC8_TSEL_STOP = 3'h0;

	// ----------------------------------------------------------------
	// State record
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] timer_count;
		logic [7:0] compare_value_a;
		logic [7:0] compare_value_b;
		logic [7:0] buffer_a;
		logic [7:0] buffer_b;
		logic [2:0] waveform_select;
		logic [1:0] output_action_select_a;
		logic [1:0] output_action_select_b;
		logic [2:0] tick_source_select;
		logic overflow_flag;
		logic compare_flag_a;
		logic compare_flag_b;
		logic [2:0] irq_enable;
		logic [1:0] port_data;
		logic [1:0] port_dir;
		logic compare_output_a;
		logic compare_output_b;
		logic block;
		logic [1:0] pin_out;
		logic [1:0] pin_oe;
		logic [2:0] irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} tc8_state_t;

	localparam tc8_state_t TC8_STATE_RST = '0;

endpackage : tc8_pkg

// ==== verilog/tc8_timer.sv ====
/*
 * 8-bit timer with two compare channels, Normal and clear-on-match
 * counting, compare outputs with port override, APB register access.
 * Assumes timer_tick is a one-cycle pulse synchronous to clk and that
 * irq_ack pulses once when the matching interrupt is serviced.
 */
`timescale 1ns/10ps

module tc8_timer
	import tc8_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic timer_tick,
	input wire logic [2:0] irq_ack,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [2:0] irq,
	output logic [1:0] pin_out,
	output logic [1:0] pin_oe
);

	tc8_state_t st_q;
	tc8_state_t st_d;
	logic tick;
	logic pwm;
	logic match_a;
	logic match_b;
	logic hit_a;
	logic hit_b;
	logic wr;
	logic cnt_wr;
	logic force_wr;
	logic flag_wr;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic act_apply(input logic [1:0] act, input logic cur);
		logic r;
		r = cur;
		unique case (act)
			TC8_ACT_NONE: r = cur;
			TC8_ACT_TOGGLE: r = ~cur;
			TC8_ACT_CLEAR: r = 1'b0;
			TC8_ACT_SET: r = 1'b1;
		endcase
		return r;
	endfunction : act_apply

	function automatic logic mapped(input logic [7:0] a);
		return a == TC8_OFF_CTRL || a == TC8_OFF_COUNT || a == TC8_OFF_CMPA || a == TC8_OFF_CMPB ||
			a == TC8_OFF_FLAGS || a == TC8_OFF_IEN || a == TC8_OFF_FORCE || a == TC8_OFF_PORT;
	endfunction : mapped

	function automatic logic [31:0] read_mux(input tc8_state_t s, input logic [7:0] a, input logic p);
		logic [31:0] r;
		r = '0;
		unique case (a)
			TC8_OFF_CTRL: begin
				r[TC8_CTRL_WSEL_LSB +: 3] = s.waveform_select;
				r[TC8_CTRL_ACTA_LSB +: 2] = s.output_action_select_a;
				r[TC8_CTRL_ACTB_LSB +: 2] = s.output_action_select_b;
				r[TC8_CTRL_TSEL_LSB +: 3] = s.tick_source_select;
			end
			TC8_OFF_COUNT: r[7:0] = s.timer_count;
			TC8_OFF_CMPA: r[7:0] = p ? s.buffer_a : s.compare_value_a;
			TC8_OFF_CMPB: r[7:0] = p ? s.buffer_b : s.compare_value_b;
			TC8_OFF_FLAGS: begin
				r[TC8_FLAG_OVF] = s.overflow_flag;
				r[TC8_FLAG_A] = s.compare_flag_a;
				r[TC8_FLAG_B] = s.compare_flag_b;
			end
			TC8_OFF_IEN: r[2:0] = s.irq_enable;
			TC8_OFF_PORT: begin
				r[TC8_PORT_DATA_LSB +: 2] = s.port_data;
				r[TC8_PORT_DIR_LSB +: 2] = s.port_dir;
			end
			default: r = '0;
		endcase
		return r;
	endfunction : read_mux

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	assign tick = timer_tick && st_q.tick_source_select != TC8_TSEL_STOP;
	assign pwm = st_q.waveform_select[0];
	assign match_a = st_q.timer_count == st_q.compare_value_a;
	assign match_b = st_q.timer_count == st_q.compare_value_b;
	assign hit_a = tick && match_a && !st_q.block;
	assign hit_b = tick && match_b && !st_q.block;
	// Writes land at the edge where pready is seen high
	assign wr = psel && penable && st_q.pready && pwrite;
	assign cnt_wr = wr && paddr == TC8_OFF_COUNT;
	assign force_wr = wr && paddr == TC8_OFF_FORCE;
	assign flag_wr = wr && paddr == TC8_OFF_FLAGS;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.pready = 1'b0;
		st_d.pslverr = 1'b0;
		if (psel && penable && !st_q.pready) begin
			st_d.pready = 1'b1;
			st_d.pslverr = !mapped(paddr);
			st_d.prdata = pwrite ? '0 : read_mux(st_q, paddr, pwm);
		end
		if (wr) begin
			unique case (paddr)
				TC8_OFF_CTRL: begin
					st_d.waveform_select = pwdata[TC8_CTRL_WSEL_LSB +: 3];
					st_d.output_action_select_a = pwdata[TC8_CTRL_ACTA_LSB +: 2];
					st_d.output_action_select_b = pwdata[TC8_CTRL_ACTB_LSB +: 2];
					st_d.tick_source_select = pwdata[TC8_CTRL_TSEL_LSB +: 3];
				end
				TC8_OFF_CMPA: begin
					if (pwm) st_d.buffer_a = pwdata[7:0];
					else st_d.compare_value_a = pwdata[7:0];
				end
				TC8_OFF_CMPB: begin
					if (pwm) st_d.buffer_b = pwdata[7:0];
					else st_d.compare_value_b = pwdata[7:0];
				end
				TC8_OFF_IEN: st_d.irq_enable = pwdata[2:0];
				TC8_OFF_PORT: begin
					st_d.port_data = pwdata[TC8_PORT_DATA_LSB +: 2];
					st_d.port_dir = pwdata[TC8_PORT_DIR_LSB +: 2];
				end
				default: ;
			endcase
		end
		// Clears first so a same-cycle set wins
		if (flag_wr) begin
			if (pwdata[TC8_FLAG_OVF]) st_d.overflow_flag = 1'b0;
			if (pwdata[TC8_FLAG_A]) st_d.compare_flag_a = 1'b0;
			if (pwdata[TC8_FLAG_B]) st_d.compare_flag_b = 1'b0;
		end
		if (irq_ack[TC8_FLAG_OVF]) st_d.overflow_flag = 1'b0;
		if (irq_ack[TC8_FLAG_A]) st_d.compare_flag_a = 1'b0;
		if (irq_ack[TC8_FLAG_B]) st_d.compare_flag_b = 1'b0;
		if (force_wr && !pwm) begin
			if (pwdata[0]) st_d.compare_output_a = act_apply(st_q.output_action_select_a, st_q.compare_output_a);
			if (pwdata[1]) st_d.compare_output_b = act_apply(st_q.output_action_select_b, st_q.compare_output_b);
		end
		if (tick) begin
			st_d.block = 1'b0;
			if (st_q.waveform_select == TC8_WSEL_CLEAR_ON_MATCH && match_a) begin
				st_d.timer_count = TC8_COUNT_BOTTOM;
			end else begin
				st_d.timer_count = st_q.timer_count + 8'h01;
			end
			if (st_q.timer_count == TC8_COUNT_MAX) begin
				st_d.overflow_flag = 1'b1;
				if (pwm) begin
					// Buffered values go live only at the wrap
					st_d.compare_value_a = st_q.buffer_a;
					st_d.compare_value_b = st_q.buffer_b;
				end
			end
			if (hit_a) begin
				st_d.compare_flag_a = 1'b1;
				st_d.compare_output_a = act_apply(st_q.output_action_select_a, st_q.compare_output_a);
			end
			if (hit_b) begin
				st_d.compare_flag_b = 1'b1;
				st_d.compare_output_b = act_apply(st_q.output_action_select_b, st_q.compare_output_b);
			end
		end
		// Last so it overrides any count or clear above
		if (cnt_wr) begin
			st_d.timer_count = pwdata[7:0];
			st_d.block = 1'b1;
		end
		st_d.irq = {st_d.compare_flag_b, st_d.compare_flag_a, st_d.overflow_flag} & st_d.irq_enable;
		st_d.pin_out[0] = st_d.output_action_select_a != TC8_ACT_NONE ? st_d.compare_output_a : st_d.port_data[0];
		st_d.pin_out[1] = st_d.output_action_select_b != TC8_ACT_NONE ? st_d.compare_output_b : st_d.port_data[1];
		st_d.pin_oe = st_d.port_dir;
	end

	// Compare outputs survive mode writes: only matches, forces and reset touch them
	always_ff @(posedge clk) begin
		if (sys_rst) st_q <= TC8_STATE_RST;
		else st_q <= st_d;
	end

	assign prdata = st_q.prdata;
	assign pready = st_q.pready;
	assign pslverr = st_q.pslverr;
	assign irq = st_q.irq;
	assign pin_out = st_q.pin_out;
	assign pin_oe = st_q.pin_oe;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_flag_next_tick;
		hit_a && !st_q.compare_flag_a |=> st_q.compare_flag_a;
	endproperty
	a_flag_next_tick: assert property (p_flag_next_tick) else $error("flag A not set after match");

	// Checker helper: a count write stays pending until the tick it blocks
	// A stopped timer may hold it pending for any number of cycles
	logic wr_pend_q;
	always_ff @(posedge clk) begin
		if (sys_rst) wr_pend_q <= 1'b0;
		else if (cnt_wr) wr_pend_q <= 1'b1;
		else if (tick) wr_pend_q <= 1'b0;
	end

	property p_block_after_write;
		tick && wr_pend_q && !st_q.compare_flag_a && !st_q.compare_flag_b
			|=> !st_q.compare_flag_a && !st_q.compare_flag_b;
	endproperty
	a_block_after_write: assert property (p_block_after_write) else $error("match not blocked after count write");

	property p_ctc_clear;
		tick && st_q.waveform_select == TC8_WSEL_CLEAR_ON_MATCH && match_a && !cnt_wr |=> st_q.timer_count == 8'h00;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear) else $error("count not cleared at value A");

	property p_normal_wrap;
		tick && st_q.waveform_select == TC8_WSEL_NORMAL && st_q.timer_count == 8'hFF && !cnt_wr
			|=> st_q.timer_count == 8'h00 && st_q.overflow_flag;
	endproperty
	a_normal_wrap: assert property (p_normal_wrap) else $error("no wrap with overflow");

	property p_stopped;
		st_q.tick_source_select == TC8_TSEL_STOP && !cnt_wr |=> $stable(st_q.timer_count);
	endproperty
	a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

	property p_force_no_flag;
		force_wr && !tick && !st_q.compare_flag_a |=> !st_q.compare_flag_a && $stable(st_q.timer_count);
	endproperty
	a_force_no_flag: assert property (p_force_no_flag) else $error("force changed flag or count");

	property p_w1c;
		flag_wr && pwdata[TC8_FLAG_A] && !hit_a |=> !st_q.compare_flag_a;
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag A not cleared by write of one");

	property p_act_zero;
		hit_a && st_q.output_action_select_a == TC8_ACT_NONE && !force_wr |=> $stable(st_q.compare_output_a);
	endproperty
	a_act_zero: assert property (p_act_zero) else $error("output moved with action zero");

	property p_override;
		##1 st_q.output_action_select_a != TC8_ACT_NONE |-> pin_out[0] == st_q.compare_output_a && pin_oe == st_q.port_dir;
	endproperty
	a_override: assert property (p_override) else $error("pin A not overridden");

	property p_irq;
		st_q.compare_flag_a && st_q.irq_enable[TC8_FLAG_A] |-> irq[TC8_FLAG_A];
	endproperty
	a_irq: assert property (p_irq) else $error("enabled flag without irq");

	property p_apb_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("apb answer late");

	property p_flag_b_next_tick;
		hit_b && !st_q.compare_flag_b |=> st_q.compare_flag_b;
	endproperty
	a_flag_b_next_tick: assert property (p_flag_b_next_tick) else $error("flag B not set after match");

	property p_ctc_top_flag;
		tick && st_q.waveform_select == TC8_WSEL_CLEAR_ON_MATCH && match_a && !st_q.block
			|=> st_q.compare_flag_a;
	endproperty
	a_ctc_top_flag: assert property (p_ctc_top_flag) else $error("flag A not set at top");

	property p_ovf_max;
		tick && st_q.timer_count == TC8_COUNT_MAX |=> st_q.overflow_flag;
	endproperty
	a_ovf_max: assert property (p_ovf_max) else $error("overflow flag not set on wrap");

	property p_write_wins;
		cnt_wr |=> st_q.timer_count == $past(pwdata[7:0]);
	endproperty
	a_write_wins: assert property (p_write_wins) else $error("count write lost");

	property p_toggle;
		hit_a && st_q.output_action_select_a == TC8_ACT_TOGGLE
			|=> st_q.compare_output_a != $past(st_q.compare_output_a);
	endproperty
	a_toggle: assert property (p_toggle) else $error("output A did not toggle");

	property p_mode_keeps;
		wr && paddr == TC8_OFF_CTRL && !hit_a |=> $stable(st_q.compare_output_a);
	endproperty
	a_mode_keeps: assert property (p_mode_keeps) else $error("control write moved output A");

	// Buffered value may only go live at the wrap tick
	property p_pwm_buffer;
		wr && paddr == TC8_OFF_CMPA && pwm && !(tick && st_q.timer_count == TC8_COUNT_MAX)
			|=> $stable(st_q.compare_value_a);
	endproperty
	a_pwm_buffer: assert property (p_pwm_buffer) else $error("buffered write reached active value");

	// Checked through reset, so the default disable is overridden
	property p_reset_out;
		@(posedge clk) disable iff (1'b0) sys_rst |=> !st_q.compare_output_a && !st_q.compare_output_b;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("compare outputs not cleared by reset");

	c_ctc_toggle: cover property (hit_a && st_q.waveform_select == TC8_WSEL_CLEAR_ON_MATCH &&
		st_q.output_action_select_a == TC8_ACT_TOGGLE);
	c_normal_ovf: cover property (tick && st_q.timer_count == 8'hFF && st_q.waveform_select == TC8_WSEL_NORMAL);
	c_blocked: cover property (tick && st_q.block && (match_a || match_b));
	c_force_out: cover property (force_wr && !pwm && st_q.output_action_select_b != TC8_ACT_NONE);
	c_pwm_load: cover property (tick && pwm && st_q.timer_count == TC8_COUNT_MAX);

endmodule : tc8_timer

// ==== verif/tc8_cpu_model.sv ====
/*
 * Processor-side model for tc8_timer: APB master tasks and interrupt servicing.
 * Assumes it shares clk with the timer and that tb calls its tasks in order.
 */
`timescale 1ns/10ps
module tc8_cpu_model (
	input wire logic clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	output logic [2:0] irq_ack,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		irq_ack = 3'h0;
	end

	// ------------------------------------------------------------
	// Bus and service tasks
	// ------------------------------------------------------------
	// Request held until pready is seen high at a rising edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Wait on rising edges only; the bench timeout ends a hang
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		// Answer taken at the edge that sees pready, then released
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released data must not look valid
		pwdata <= ~d;
	endtask : xfer

	task automatic ack(input int b);
		@(posedge clk);
		irq_ack <= 3'h1 << b;
		@(posedge clk);
		irq_ack <= 3'h0;
	endtask : ack
endmodule : tc8_cpu_model

// ==== verif/tb.sv ====
/*
 * Self-checking bench for tc8_timer: registers through the processor model,
 * tick pulses from here, checks on flags, count, irq and pins.
 * Assumes tc8_pkg and tc8_cpu_model are compiled first.
 */
`timescale 1ns/10ps
module tb;
	import tc8_pkg::*;
	logic clk, sys_rst, timer_tick;
	logic psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] irq_ack, irq;
	logic [1:0] pin_out, pin_oe;
	int miscompares;
	int check_count;
	int cycles;

	tc8_timer dut_u (.clk(clk), .sys_rst(sys_rst), .timer_tick(timer_tick), .irq_ack(irq_ack),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .pin_out(pin_out),
		.pin_oe(pin_oe));
	tc8_cpu_model cpu_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .irq_ack(irq_ack), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task report_and_stop;
		$display("Checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			miscompares++;
			$display("Error at %0t: run hung", $time);
			report_and_stop();
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d);
		cpu_u.xfer(1'b1, a, d, rd, err);
	endtask : wr

	task rchk(input logic [7:0] a, input logic [31:0] exp);
		cpu_u.xfer(1'b0, a, 32'h0, rd, err);
		chk(rd, exp);
	endtask : rchk

	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	task pins(input logic [3:0] e);
		settle();
		chk({28'h0, pin_oe, pin_out}, {28'h0, e});
	endtask : pins

	task tick(input int n);
		repeat (n) begin
			@(posedge clk);
			timer_tick <= 1'b1;
			@(posedge clk);
			timer_tick <= 1'b0;
		end
		settle();
	endtask : tick

	function automatic logic [31:0] ctrl(input logic [2:0] w, input logic [1:0] a, input logic [1:0] b,
		input logic [2:0] t);
		return {21'h0, t, b, a, 1'b0, w};
	endfunction : ctrl

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		timer_tick = 1'b0;
		miscompares = 0;
		check_count = 0;
		cycles = 0;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		pins(4'h0);
		rchk(TC8_OFF_CTRL, 32'h0);
		rchk(TC8_OFF_COUNT, 32'h0);
		cpu_u.xfer(1'b0, 8'h40, 32'h0, rd, err);
		chk({31'h0, err}, 32'h1);
		$display("Test reset done");
		wr(TC8_OFF_COUNT, 32'hFD);
		tick(2);
		rchk(TC8_OFF_COUNT, 32'hFD);
		wr(TC8_OFF_CTRL, ctrl(TC8_WSEL_NORMAL, TC8_ACT_NONE, TC8_ACT_NONE, 3'h1));
		tick(2);
		rchk(TC8_OFF_FLAGS, 32'h0);
		tick(1);
		rchk(TC8_OFF_COUNT, 32'h0);
		rchk(TC8_OFF_FLAGS, 32'h1);
		tick(1);
		rchk(TC8_OFF_FLAGS, 32'h7);
		wr(TC8_OFF_FLAGS, 32'h0);
		rchk(TC8_OFF_FLAGS, 32'h7);
		wr(TC8_OFF_FLAGS, 32'h2);
		rchk(TC8_OFF_FLAGS, 32'h5);
		wr(TC8_OFF_IEN, 32'h5);
		settle();
		chk({29'h0, irq}, 32'h5);
		cpu_u.ack(2);
		cpu_u.ack(0);
		settle();
		chk({29'h0, irq}, 32'h0);
		rchk(TC8_OFF_FLAGS, 32'h0);
		$display("Test normal done");
		wr(TC8_OFF_CTRL, ctrl(TC8_WSEL_NORMAL, TC8_ACT_NONE, TC8_ACT_NONE, 3'h0));
		wr(TC8_OFF_CMPB, 32'h10);
		wr(TC8_OFF_COUNT, 32'h10);
		wr(TC8_OFF_CTRL, ctrl(TC8_WSEL_NORMAL, TC8_ACT_NONE, TC8_ACT_NONE, 3'h1));
		tick(2);
		rchk(TC8_OFF_FLAGS, 32'h0);
		wr(TC8_OFF_COUNT, 32'h0F);
		tick(2);
		rchk(TC8_OFF_FLAGS, 32'h4);
		wr(TC8_OFF_FLAGS, 32'h7);
		$display("Test blocking done");
		wr(TC8_OFF_CTRL, ctrl(TC8_WSEL_NORMAL, TC8_ACT_NONE, TC8_ACT_SET, 3'h1));
		wr(TC8_OFF_PORT, 32'h1);
		pins(4'h1);
		wr(TC8_OFF_FORCE, 32'h2);
		pins(4'h3);
		rchk(TC8_OFF_COUNT, 32'h11);
		rchk(TC8_OFF_FLAGS, 32'h0);
		// Output state first, pin drive afterwards
		wr(TC8_OFF_PORT, 32'h31);
		pins(4'hF);
		wr(TC8_OFF_CTRL, ctrl(TC8_WSEL_CLEAR_ON_MATCH, TC8_ACT_TOGGLE, TC8_ACT_NONE, 3'h1));
		pins(4'hC);
		$display("Test force done");
		wr(TC8_OFF_CMPA, 32'h2);
		wr(TC8_OFF_CMPB, 32'h1);
		wr(TC8_OFF_COUNT, 32'h0);
		wr(TC8_OFF_FLAGS, 32'h7);
		tick(2);
		rchk(TC8_OFF_COUNT, 32'h2);
		tick(1);
		rchk(TC8_OFF_COUNT, 32'h0);
		rchk(TC8_OFF_FLAGS, 32'h6);
		pins(4'hD);
		tick(2);
		pins(4'hD);
		tick(1);
		pins(4'hC);
		wr(TC8_OFF_CTRL, ctrl(TC8_WSEL_CLEAR_ON_MATCH, TC8_ACT_TOGGLE, TC8_ACT_TOGGLE, 3'h1));
		pins(4'hE);
		tick(2);
		pins(4'hC);
		wr(TC8_OFF_CMPA, 32'h1);
		wr(TC8_OFF_FLAGS, 32'h7);
		tick(253);
		rchk(TC8_OFF_COUNT, 32'hFF);
		tick(1);
		rchk(TC8_OFF_FLAGS, 32'h1);
		$display("Test clear on match done");
		wr(TC8_OFF_FLAGS, 32'h7);
		wr(TC8_OFF_CTRL, ctrl(3'h1, TC8_ACT_TOGGLE, TC8_ACT_NONE, 3'h0));
		wr(TC8_OFF_FORCE, 32'h1);
		pins(4'hC);
		wr(TC8_OFF_CMPA, 32'h5);
		rchk(TC8_OFF_CMPA, 32'h5);
		wr(TC8_OFF_CTRL, ctrl(TC8_WSEL_NORMAL, TC8_ACT_TOGGLE, TC8_ACT_NONE, 3'h0));
		rchk(TC8_OFF_CMPA, 32'h1);
		wr(TC8_OFF_COUNT, 32'hFF);
		wr(TC8_OFF_CTRL, ctrl(3'h1, TC8_ACT_TOGGLE, TC8_ACT_NONE, 3'h1));
		tick(1);
		wr(TC8_OFF_CTRL, ctrl(TC8_WSEL_NORMAL, TC8_ACT_TOGGLE, TC8_ACT_NONE, 3'h0));
		rchk(TC8_OFF_CMPA, 32'h5);
		rchk(TC8_OFF_CMPB, 32'h0);
		rchk(TC8_OFF_FLAGS, 32'h1);
		$display("Test buffering done");
		report_and_stop();
	end
endmodule : tb
